// ---- shared/eoc_pkg.sv ----
// constants for the external oscillator control block
package eoc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register address and layout
  localparam logic [7:0] EOC_CTRL_ADDR = 8'hb1;
  localparam logic [7:0] EOC_CTRL_RESET = 8'h00;
  localparam int EOC_STABLE_BIT = 7;
  localparam int EOC_TYPE_MSB = 6;
  localparam int EOC_TYPE_LSB = 4;
  localparam int EOC_UNUSED_BIT = 3;
  localparam int EOC_FREQ_MSB = 2;
  localparam int EOC_FREQ_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator type codes
  typedef enum logic [2:0] {
    EOC_TYPE_OFF = 3'h0,
    EOC_TYPE_SPARE = 3'h1,
    EOC_TYPE_CMOS = 3'h2,
    EOC_TYPE_CMOS_DIV2 = 3'h3,
    EOC_TYPE_RC = 3'h4,
    EOC_TYPE_CAP = 3'h5,
    EOC_TYPE_XTAL = 3'h6,
    EOC_TYPE_XTAL_DIV2 = 3'h7
  } eoc_type_t;

  ////////////////////////////////////////////////////////////////////////////
  // frequency range codes at the ends of the scale
  localparam logic [2:0] EOC_FREQ_LOWEST = 3'h0;
  localparam logic [2:0] EOC_FREQ_HIGHEST = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // stability qualification: amplitude must hold this long
  localparam int EOC_CLK_MHZ = 20;
  localparam int EOC_QUAL_TIME_US = 4;
  localparam int EOC_QUAL_CYCLES = EOC_QUAL_TIME_US * EOC_CLK_MHZ;

endpackage : eoc_pkg

// ---- rtl/eoc_stable_detect.sv ----
// crystal amplitude qualification producing the stable flag
`timescale 1ns/1ps

module eoc_stable_detect #(
  parameter int QUAL_CYCLES = eoc_pkg::EOC_QUAL_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_amp_ok,
  output logic o_stable
);

  localparam int CW = $clog2(QUAL_CYCLES + 1);
  localparam logic [CW-1:0] QUAL_LAST = CW'(QUAL_CYCLES);

  typedef enum logic [1:0] {
    EOC_DET_IDLE = 2'b00,
    EOC_DET_WAIT = 2'b01,
    EOC_DET_STABLE = 2'b10
  } eoc_det_t;

  eoc_det_t state_r;
  eoc_det_t state_nxt;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic stable_r;
  logic stable_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // next state: count consecutive good amplitude cycles
  always_comb
  begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      EOC_DET_IDLE:
      begin
        count_nxt = '0;
        if (i_enable)
          state_nxt = EOC_DET_WAIT;
      end
      EOC_DET_WAIT:
      begin
        if (!i_enable)
          state_nxt = EOC_DET_IDLE;
        else if (!i_amp_ok)
          count_nxt = '0;
        else if (count_r == QUAL_LAST - CW'(1))
          state_nxt = EOC_DET_STABLE;
        else
          count_nxt = count_r + CW'(1);
      end
      EOC_DET_STABLE:
      begin
        if (!i_enable)
          state_nxt = EOC_DET_IDLE;
        else if (!i_amp_ok)
        begin
          state_nxt = EOC_DET_WAIT;
          count_nxt = '0;
        end
      end
      default:
      begin
        state_nxt = EOC_DET_IDLE;
        count_nxt = '0;
      end
    endcase
  end

  assign stable_nxt = (state_nxt == EOC_DET_STABLE);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= EOC_DET_IDLE;
      count_r <= '0;
      stable_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      stable_r <= stable_nxt;
    end
  end

  assign o_stable = stable_r;

endmodule : eoc_stable_detect

// ---- rtl/eoc_external_oscillator_control.sv ----
// external oscillator control register and pin steering
//
// What this block does
// - bit 7 reads 1 only while crystal mode runs and is stable
// - stable flag reads 0 while unused or not yet settled
// - bits 6:4 select oscillator type; 111 is crystal divided by two
// - bit 3 always reads zero; writes to it are ignored
// - first crystal pin only in crystal mode; second in all external modes
`timescale 1ns/1ps

module eoc_external_oscillator_control #(
  parameter int QUAL_CYCLES = eoc_pkg::EOC_QUAL_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_sel,
  input wire logic i_amp_ok,
  output logic [2:0] o_ext_osc_type_select,
  output logic [2:0] o_ext_osc_frequency_range,
  output logic o_osc_drive_en,
  output logic o_crystal_amp_en,
  output logic o_rc_mode,
  output logic o_cap_mode,
  output logic o_cmos_mode,
  output logic o_div2_en,
  output logic o_crystal_input_pin_used,
  output logic o_crystal_output_pin_used,
  output logic o_crystal_stable_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release synchroniser
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // type decode helpers
  function automatic logic is_crystal(input logic [2:0] t);
    is_crystal = (t == eoc_pkg::EOC_TYPE_XTAL) ||
                 (t == eoc_pkg::EOC_TYPE_XTAL_DIV2);
  endfunction : is_crystal

  function automatic logic is_external(input logic [2:0] t);
    is_external = (t == eoc_pkg::EOC_TYPE_CMOS) ||
                  (t == eoc_pkg::EOC_TYPE_CMOS_DIV2) ||
                  (t == eoc_pkg::EOC_TYPE_RC) ||
                  (t == eoc_pkg::EOC_TYPE_CAP) ||
                  is_crystal(t);
  endfunction : is_external

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [2:0] type_r;
  logic [2:0] type_nxt;
  logic [2:0] freq_r;
  logic [2:0] freq_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic stable;
  wire hit = (i_sfr_addr == eoc_pkg::EOC_CTRL_ADDR);
  wire wr_hit = hit & i_sfr_wr;
  wire rd_hit = hit & i_sfr_rd;
  wire crystal_on = is_crystal(type_r);

  // bit 3 is never stored
  assign type_nxt = wr_hit ?
    i_sfr_wdata[eoc_pkg::EOC_TYPE_MSB:eoc_pkg::EOC_TYPE_LSB] : type_r;
  assign freq_nxt = wr_hit ?
    i_sfr_wdata[eoc_pkg::EOC_FREQ_MSB:eoc_pkg::EOC_FREQ_LSB] : freq_r;

  ////////////////////////////////////////////////////////////////////////////
  // read image: flag, type, zero, range
  wire [7:0] image = {stable & crystal_on, type_r, 1'b0, freq_r};
  assign rdata_nxt = rd_hit ? image : 8'h00;

  always_ff @(posedge i_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      type_r <= eoc_pkg::EOC_CTRL_RESET[eoc_pkg::EOC_TYPE_MSB:
                                        eoc_pkg::EOC_TYPE_LSB];
      freq_r <= eoc_pkg::EOC_CTRL_RESET[eoc_pkg::EOC_FREQ_MSB:
                                        eoc_pkg::EOC_FREQ_LSB];
      rdata_r <= 8'h00;
    end
    else
    begin
      type_r <= type_nxt;
      freq_r <= freq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stability detection runs only in crystal modes
  eoc_stable_detect #(
    .QUAL_CYCLES(QUAL_CYCLES)
  ) u_detect (
    .i_clk(i_clk),
    .i_rst_n(rst_sync_r),
    .i_enable(crystal_on),
    .i_amp_ok(i_amp_ok),
    .o_stable(stable)
  );

  ////////////////////////////////////////////////////////////////////////////
  // drive circuit steering
  assign o_sfr_rdata = rdata_r;
  assign o_sfr_sel = hit;
  assign o_ext_osc_type_select = type_r;
  assign o_ext_osc_frequency_range = freq_r;
  assign o_osc_drive_en = is_external(type_r);
  assign o_crystal_amp_en = crystal_on;
  assign o_rc_mode = (type_r == eoc_pkg::EOC_TYPE_RC);
  assign o_cap_mode = (type_r == eoc_pkg::EOC_TYPE_CAP);
  assign o_cmos_mode = (type_r == eoc_pkg::EOC_TYPE_CMOS) ||
                       (type_r == eoc_pkg::EOC_TYPE_CMOS_DIV2);
  assign o_div2_en = (type_r == eoc_pkg::EOC_TYPE_CMOS_DIV2) ||
                     (type_r == eoc_pkg::EOC_TYPE_XTAL_DIV2);
  assign o_crystal_input_pin_used = crystal_on;
  assign o_crystal_output_pin_used = is_external(type_r);
  assign o_crystal_stable_flag = stable & crystal_on;

endmodule : eoc_external_oscillator_control

// ---- bench/eoc_monitor.sv ----
// assertions on the oscillator control ports
`timescale 1ns/1ps
module eoc_monitor (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_sfr_sel,
  input wire logic i_amp_ok,
  input wire logic [2:0] o_ext_osc_type_select,
  input wire logic [2:0] o_ext_osc_frequency_range,
  input wire logic o_crystal_input_pin_used,
  input wire logic o_crystal_output_pin_used,
  input wire logic o_crystal_stable_flag
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire xt = o_ext_osc_type_select[2:1] == 2'h3;
  wire [2:0] w_type = i_sfr_wdata[6:4];
  wire [2:0] w_freq = i_sfr_wdata[2:0];
  wire [2:0] ty = o_ext_osc_type_select;
  wire [2:0] fr = o_ext_osc_frequency_range;
  wire rd_hit = i_sfr_rd && o_sfr_sel;
  wire wr_hit = i_sfr_wr && o_sfr_sel;
  ////////////////////////////////////////////////////////////////////////////
  bit_zero_a: assert property (o_sfr_rdata[3] == 1'b0)
    else $error("bit 3 read as one");
  rd_image_a: assert property (rd_hit |=> o_sfr_rdata ==
    {$past(o_crystal_stable_flag), $past(ty), 1'b0, $past(fr)})
    else $error("read data differs from register");
  rd_idle_a: assert property (!rd_hit |=> o_sfr_rdata == 8'h00)
    else $error("read data not zero when idle");
  wr_field_a: assert property (wr_hit |=>
    ty == $past(w_type) && fr == $past(w_freq))
    else $error("written fields not taken");
  hold_field_a: assert property (!wr_hit |=> $stable(ty) && $stable(fr))
    else $error("fields changed without write");
  flag_gate_a: assert property (o_crystal_stable_flag |-> xt)
    else $error("flag set outside crystal mode");
  amp_drop_a: assert property (!i_amp_ok |=> !o_crystal_stable_flag)
    else $error("flag kept after amplitude loss");
  pin_claim_a: assert property (o_crystal_input_pin_used == xt &&
    o_crystal_output_pin_used == (ty > 3'h1))
    else $error("pin claim wrong for type");
endmodule : eoc_monitor

// ---- bench/eoc_xtal_model.sv ----
// crystal model: amplitude builds some cycles after drive starts
`timescale 1ns/1ps
module eoc_xtal_model #(
  parameter int START = 20
) (
  input wire logic i_clk,
  input wire logic i_drive_en,
  input wire logic i_stop,
  output logic o_amp_ok = 1'b0
);
  int cnt = 0;
  always @(posedge i_clk)
  begin
    cnt <= i_drive_en ? cnt + 1 : 0;
    o_amp_ok <= i_drive_en && !i_stop && cnt >= START;
  end
endmodule : eoc_xtal_model

// ---- bench/test_eoc_external_oscillator_control.sv ----
// self-checking bench for the oscillator control block
`timescale 1ns/1ps
module test_eoc_external_oscillator_control;
  localparam int QUAL = 4;
  localparam int START = 20;
  logic i_clk = 0, i_reset_n = 0, i_sfr_wr = 0, i_sfr_rd = 0, stop = 0;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, rv, e;
  logic [2:0] o_ext_osc_type_select, o_ext_osc_frequency_range;
  logic o_sfr_sel, i_amp_ok, o_osc_drive_en, o_crystal_amp_en, o_rc_mode;
  logic o_cap_mode, o_cmos_mode, o_div2_en, o_crystal_stable_flag;
  logic o_crystal_input_pin_used, o_crystal_output_pin_used;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  wire [7:0] modes = {o_osc_drive_en, o_crystal_amp_en, o_rc_mode,
    o_cap_mode, o_cmos_mode, o_div2_en, o_crystal_input_pin_used,
    o_crystal_output_pin_used};
  eoc_external_oscillator_control #(.QUAL_CYCLES(QUAL))
    eoc_external_oscillator_control_inst (.i_clk, .i_reset_n, .i_sfr_addr,
    .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata, .o_sfr_sel, .i_amp_ok,
    .o_ext_osc_type_select, .o_ext_osc_frequency_range, .o_osc_drive_en,
    .o_crystal_amp_en, .o_rc_mode, .o_cap_mode, .o_cmos_mode, .o_div2_en,
    .o_crystal_input_pin_used, .o_crystal_output_pin_used,
    .o_crystal_stable_flag);
  eoc_xtal_model #(.START(START)) eoc_xtal_model_inst (.i_clk,
    .i_drive_en(o_crystal_amp_en), .i_stop(stop), .o_amp_ok(i_amp_ok));
  initial forever #25 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #5 i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1;
    @(posedge i_clk);
    #5 i_sfr_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #5 i_sfr_addr = a;
    i_sfr_rd = 1;
    @(posedge i_clk);
    #5 i_sfr_rd = 0;
    d = o_sfr_rdata;
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_types();
    logic [2:0] c;
    for (int i = 0; i < 8; i++)
    begin
      c = i[2:0];
      wr(8'hb1, {1'b1, c, 1'b1, c});
      rd(8'hb1, rv);
      cmp(rv, {1'b0, c, 1'b0, c});
      e = {c > 1, c > 5, c == 4, c == 5, c[2:1] == 1, &c[1:0], c > 5, c > 1};
      cmp(modes, e);
      cmp({1'b0, o_ext_osc_type_select, 1'b0, o_ext_osc_frequency_range},
        {1'b0, c, 1'b0, c});
    end
  endtask : t_types
  task automatic t_stable();
    wr(8'hb1, 8'h00);
    wr(8'hb1, 8'h67);
    repeat (START - 4) @(posedge i_clk);
    rd(8'hb1, rv);
    cmp(rv, 8'h67);
    for (int n = 0; n < 20 && rv[7] !== 1'b1; n++)
      rd(8'hb1, rv);
    cmp(rv, 8'he7);
    cmp({7'h00, o_crystal_stable_flag}, 8'h01);
    wr(8'hb1, 8'h60);
    rd(8'hb1, rv);
    cmp(rv, 8'he0);
    stop = 1;
    repeat (2) @(posedge i_clk);
    rd(8'hb1, rv);
    cmp(rv, 8'h60);
    cmp({7'h00, o_crystal_stable_flag}, 8'h00);
    stop = 0;
    repeat (QUAL + 3) @(posedge i_clk);
    rd(8'hb1, rv);
    cmp(rv, 8'he0);
    wr(8'hb1, 8'h47);
    rd(8'hb1, rv);
    cmp(rv, 8'h47);
  endtask : t_stable
  task automatic t_bus();
    wr(8'hb0, 8'hff);
    rd(8'hb0, rv);
    cmp(rv, 8'h00);
    cmp({7'h00, o_sfr_sel}, 8'h00);
    rd(8'hb1, rv);
    cmp(rv, 8'h47);
    cmp({7'h00, o_sfr_sel}, 8'h01);
    @(posedge i_clk);
    #5 i_sfr_wdata = 8'h2d;
    i_sfr_wr = 1;
    i_sfr_rd = 1;
    @(posedge i_clk);
    #5 i_sfr_wr = 0;
    i_sfr_rd = 0;
    cmp(o_sfr_rdata, 8'h47);
    rd(8'hb1, rv);
    cmp(rv, 8'h25);
  endtask : t_bus
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fail_count++;
      stop_test();
    end
  end
  initial
  begin
    repeat (3) @(posedge i_clk);
    #5 i_reset_n = 1;
    repeat (3) @(posedge i_clk);
    #5;
    rd(8'hb1, rv);
    cmp(rv, eoc_pkg::EOC_CTRL_RESET);
    t_types();
    t_stable();
    t_bus();
    stop_test();
  end
endmodule : test_eoc_external_oscillator_control
bind eoc_external_oscillator_control eoc_monitor eoc_monitor_inst (.i_clk,
  .i_reset_n, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata, .o_sfr_sel,
  .i_amp_ok, .o_ext_osc_type_select, .o_ext_osc_frequency_range,
  .o_crystal_input_pin_used, .o_crystal_output_pin_used,
  .o_crystal_stable_flag);
